// >>> hdl/afx_host.sv
// module: host that writes and reads a depth chain of async fifo devices
`timescale 1ns/1ps
// Function
// - first chain device gets its first-device select driven low after reset, high during reset
// - every later device gets first-device select held high
// - each device's handoff out feeds next device's handoff in (board wiring)
// - composite full and empty assert only when all member flags assert
// - writer watches full flag, reader watches empty flag
// - writer starts a write strobe only while full flag deasserted
module afx_host (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [afx_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output afx_pkg::afx_word_t rd_word_out,
  output afx_pkg::afx_strobe_t strobe_out,
  output logic [afx_pkg::DATA_W-1:0] fifo_data_out,
  input wire logic [afx_pkg::DATA_W-1:0] fifo_q_in,
  input wire logic [afx_pkg::NDEV-1:0] full_flag_n_in,
  input wire logic [afx_pkg::NDEV-1:0] empty_flag_n_in,
  output logic [afx_pkg::NDEV-1:0] first_device_select_out,
  output logic comp_full_out,
  output logic comp_empty_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_WLOW, ST_RLOW, ST_REC} afx_state_t;
  afx_state_t st_q;
  logic [3:0] tmr_q;
  logic is_write_q;
  logic [afx_pkg::NDEV-1:0] ff_s1_q, ff_s2_q, ef_s1_q, ef_s2_q;
  logic [afx_pkg::DATA_W-1:0] q_s1_q, q_s2_q;
  logic [afx_pkg::DATA_W-1:0] buf_data;
  logic buf_valid;
  logic pop;
  afx_pkg::afx_strobe_t strobe_q;
  afx_pkg::afx_word_t word_q;
  logic [afx_pkg::DATA_W-1:0] dout_q;
  logic cfull_q, cempty_q;

  afx_buf #(.WIDTH(afx_pkg::DATA_W), .DEPTH(afx_pkg::DEPTH), .AW(afx_pkg::PTR_W)) u_buf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(en_in),
    .in_data_in(wr_data_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .out_data_out(buf_data),
    .out_valid_out(buf_valid),
    .out_ready_in(pop)
  );

  // flags are active low; composite asserted only when every device asserts
  wire all_full = ~|ff_s2_q;
  wire all_empty = ~|ef_s2_q;
  // writer checks composite full, reader composite empty
  wire can_write = buf_valid && !all_full;
  wire can_read = !all_empty;
  wire tmr_done = (tmr_q == afx_pkg::TIMER_ZERO);
  wire start_w = (st_q == ST_IDLE) && can_write;
  wire start_r = (st_q == ST_IDLE) && !can_write && can_read;
  // word leaves the buffer on the write strobe's leading edge
  assign pop = start_w;

  // flags and data come from another timing domain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ff_s1_q <= afx_pkg::SEL_RST;
      ff_s2_q <= afx_pkg::SEL_RST;
      ef_s1_q <= '0;
      ef_s2_q <= '0;
      q_s1_q <= afx_pkg::DATA_RST;
      q_s2_q <= afx_pkg::DATA_RST;
    end else if (en_in) begin
      ff_s1_q <= full_flag_n_in;
      ff_s2_q <= ff_s1_q;
      ef_s1_q <= empty_flag_n_in;
      ef_s2_q <= ef_s1_q;
      q_s1_q <= fifo_q_in;
      q_s2_q <= q_s1_q;
    end
  end

  // strobe sequencer; one strobe at a time, pulse then recovery
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      tmr_q <= afx_pkg::TIMER_ZERO;
      is_write_q <= 1'b0;
    end else if (en_in) begin
      case (st_q)
        ST_IDLE: begin
          if (start_w) begin
            st_q <= ST_WLOW;
            is_write_q <= 1'b1;
            tmr_q <= 4'(afx_pkg::STROBE_CYC - 1);
          end else if (start_r) begin
            st_q <= ST_RLOW;
            is_write_q <= 1'b0;
            // longer wait covers flow-through delay plus sync stages
            tmr_q <= 4'(afx_pkg::FLOW_CYC + 1);
          end
        end
        ST_WLOW: if (tmr_done) begin
          st_q <= ST_REC;
          tmr_q <= 4'(afx_pkg::RECOV_CYC - 1);
        end else tmr_q <= tmr_q - 4'h1;
        ST_RLOW: if (tmr_done) begin
          // read released; data then floats, recovery covers it
          st_q <= ST_REC;
          tmr_q <= 4'(afx_pkg::FLOAT_CYC - 1);
        end else tmr_q <= tmr_q - 4'h1;
        ST_REC: if (tmr_done) st_q <= ST_IDLE;
          else tmr_q <= tmr_q - 4'h1;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // registered pin drives and user outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_q <= '{wr_n: 1'b1, rd_n: 1'b1};
      dout_q <= afx_pkg::DATA_RST;
      word_q <= '0;
      cfull_q <= 1'b0;
      cempty_q <= 1'b1;
    end else if (en_in) begin
      strobe_q.wr_n <= !(start_w || (st_q == ST_WLOW && !tmr_done));
      strobe_q.rd_n <= !(start_r || (st_q == ST_RLOW && !tmr_done));
      if (start_w) dout_q <= buf_data;
      // sample data just before read rises, while device still drives it
      word_q.valid <= (st_q == ST_RLOW) && tmr_done;
      if ((st_q == ST_RLOW) && tmr_done) word_q.data <= q_s2_q;
      cfull_q <= all_full;
      cempty_q <= all_empty;
    end
  end

  // first device selected low, all others high; fixed after reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) first_device_select_out <= afx_pkg::SEL_RST;
    else if (en_in) first_device_select_out <= {{(afx_pkg::NDEV-1){1'b1}}, 1'b0};
  end

  assign strobe_out = strobe_q;
  assign fifo_data_out = dout_q;
  assign rd_word_out = word_q;
  assign comp_full_out = cfull_q;
  assign comp_empty_out = cempty_q;

  // write strobe never starts while composite full asserted
  no_write_full_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (en_in && $fell(strobe_q.wr_n)) |-> $past(!all_full))
    else $error("write strobe started while full");
  one_strobe_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(strobe_q.wr_n == 1'b0 && strobe_q.rd_n == 1'b0))
    else $error("read and write low together");
  wr_width_a: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    $fell(strobe_q.wr_n) |-> !strobe_q.wr_n [*4])
    else $error("write strobe too short");
  rd_hold_a: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    $fell(strobe_q.rd_n) |-> !strobe_q.rd_n [*8])
    else $error("read strobe released before flow data valid");
  rd_capture_a: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    word_q.valid |-> $past(strobe_q.rd_n) == 1'b0)
    else $error("word captured outside read low");
  recover_a: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    $rose(strobe_q.rd_n) |-> strobe_q.wr_n && strobe_q.rd_n [*3])
    else $error("no float recovery after read");
  sel_fixed_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(!rst_in) |-> first_device_select_out == 3'h6)
    else $error("first device select wrong");
  comp_full_a: assert property (@(posedge clk_in) disable iff (rst_in || !en_in)
    comp_full_out |-> $past(ff_s2_q) == '0)
    else $error("composite full without all members full");
  c_write: cover property (@(posedge clk_in) $fell(strobe_q.wr_n));
  c_read: cover property (@(posedge clk_in) word_q.valid);
  c_full: cover property (@(posedge clk_in) comp_full_out && buf_valid);
endmodule : afx_host

// >>> hdl/afx_pkg.sv
// package: constants and carriers for the cascaded fifo host controller
package afx_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int NDEV = 3;
  localparam int CLK_PERIOD_NS = 8;
  // strobe timing, ns, then cycles (least times round up)
  localparam int T_STROBE_NS = 30;
  localparam int T_RECOVERY_NS = 10;
  localparam int T_WEF_NS = 30;
  localparam int T_ACCESS_NS = 30;
  localparam int T_RHZ_NS = 20;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOW_CYC = (T_WEF_NS + T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (T_RHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TIMER_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
  localparam logic [NDEV-1:0] SEL_RST = 3'h7;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } afx_word_t;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
  } afx_strobe_t;
endpackage : afx_pkg

// >>> hdl/afx_buf.sv
// module: small valid/ready fifo on flip-flops
`timescale 1ns/1ps
module afx_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  wire push = in_valid_in && in_ready_out && en_in;
  wire pop = out_valid_out && out_ready_in && en_in;

  assign cnt_d = (push && !pop) ? cnt_q + 1'b1 : ((pop && !push) ? cnt_q - 1'b1 : cnt_q);
  // ready from a flop so the host's own ready output stays glitch free
  assign in_ready_out = rdy_q;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];

  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clk_in) begin
      if (push && wp_q == AW'(i)) mem_q[i] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule : afx_buf

// >>> tb/afx_chain.sv
// behavioural depth chain of three async fifo devices
`timescale 1ns/1ps
module afx_chain #(
  parameter int DEVD = 4
) (
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic [afx_pkg::DATA_W-1:0] d_in,
  input wire logic [afx_pkg::NDEV-1:0] sel_in,
  output logic [afx_pkg::DATA_W-1:0] q_out,
  output logic [afx_pkg::NDEV-1:0] full_n_out,
  output logic [afx_pkg::NDEV-1:0] empty_n_out
);
  localparam int TOT = afx_pkg::NDEV * DEVD;
  logic [afx_pkg::DATA_W-1:0] mem [TOT];
  int cnt [afx_pkg::NDEV] = '{default: 0};
  int wp = 0;
  int rp = 0;
  bit act = 0;
  // a wrongly designated chain answers no strobe at all
  wire ok = (sel_in === 3'h6);
  initial q_out = 9'h1AA;
  // pointer owner alone answers; crossing a device edge is the handoff
  always @(negedge wr_n_in) begin
    #1;
    if (ok && cnt[wp / DEVD] < DEVD) begin
      mem[wp] = d_in;
      cnt[wp / DEVD]++;
      wp = (wp + 1) % TOT;
    end
  end
  always @(negedge rd_n_in) begin
    if (ok && cnt[rp / DEVD] > 0) begin
      act = 1;
      q_out <= #30 mem[rp];
    end
  end
  always @(posedge rd_n_in) begin
    if (act) begin
      act = 0;
      cnt[rp / DEVD]--;
      rp = (rp + 1) % TOT;
      q_out <= #20 ~q_out;
    end
  end
  // no half-full or rewind pin in depth mode
  for (genvar g = 0; g < afx_pkg::NDEV; g++) begin : g_flag
    assign full_n_out[g] = (cnt[g] != DEVD);
    assign empty_n_out[g] = (cnt[g] != 0);
  end
endmodule : afx_chain

// >>> tb/tb_afx_host.sv
// self-checking bench for the cascaded fifo host controller
`timescale 1ns/1ps
module tb_afx_host;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en_in = 1'b1;
  logic wr_valid_in = 1'b0;
  logic [afx_pkg::DATA_W-1:0] wr_data_in = 9'h000;
  logic wr_ready_out;
  logic comp_full_out;
  logic comp_empty_out;
  afx_pkg::afx_word_t rd_word_out;
  afx_pkg::afx_strobe_t strobe_out;
  logic [afx_pkg::DATA_W-1:0] fifo_data_out;
  logic [afx_pkg::DATA_W-1:0] fifo_q_in;
  logic [afx_pkg::NDEV-1:0] full_n;
  logic [afx_pkg::NDEV-1:0] empty_n;
  logic [afx_pkg::NDEV-1:0] sel;
  logic [afx_pkg::DATA_W-1:0] exp_q [$];
  logic [4:0] fh = 5'h00;
  logic [4:0] eh = 5'h1F;
  bit saw_full = 0;
  int fail_count = 0;
  int checks_done = 0;
  int bad_strobe = 0;

  afx_host DUT (.clk_in(clk_in), .rst_in(rst_in), .en_in(en_in), .wr_data_in(wr_data_in),
    .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .rd_word_out(rd_word_out),
    .strobe_out(strobe_out), .fifo_data_out(fifo_data_out), .fifo_q_in(fifo_q_in),
    .full_flag_n_in(full_n), .empty_flag_n_in(empty_n), .first_device_select_out(sel),
    .comp_full_out(comp_full_out), .comp_empty_out(comp_empty_out));
  afx_chain CHN (.wr_n_in(strobe_out.wr_n), .rd_n_in(strobe_out.rd_n), .d_in(fifo_data_out),
    .sel_in(sel), .q_out(fifo_q_in), .full_n_out(full_n), .empty_n_out(empty_n));

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  initial forever #4 clk_in = ~clk_in;
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  // composite flags judged only once member flags sat still long enough to sync
  always @(negedge clk_in) begin
    fh <= {fh[3:0], &(~full_n)};
    eh <= {eh[3:0], &(~empty_n)};
    if (comp_full_out === 1'b1) saw_full = 1;
    if (!rst_in && (fh == 5'h1F || fh == 5'h00)) chk("comp_full", comp_full_out, fh[0]);
    if (!rst_in && (eh == 5'h1F || eh == 5'h00)) chk("comp_empty", comp_empty_out, eh[0]);
    if (rd_word_out.valid === 1'b1) begin
      if (exp_q.size() == 0) chk("extra_word", 1'b1, 1'b0);
      else chk("rd_data", rd_word_out.data, exp_q.pop_front());
    end
  end
  always @(negedge strobe_out.wr_n) if (!rst_in && !(|full_n)) bad_strobe++;
  always @(negedge strobe_out.rd_n) if (!rst_in && !(|empty_n)) bad_strobe++;

  // short wait on ready so a full buffer shows up as a refusal
  task automatic push(input logic [8:0] w, output bit ok);
    int n;
    n = 0;
    wr_data_in = w;
    wr_valid_in = 1'b1;
    while (wr_ready_out !== 1'b1 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    ok = (wr_ready_out === 1'b1);
    if (ok) exp_q.push_back(w);
    else wr_valid_in = 1'b0;
    @(negedge clk_in);
  endtask : push

  task automatic drain;
    int n;
    n = 0;
    wr_valid_in = 1'b0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (8) @(negedge clk_in);
    chk("left_words", 10'(exp_q.size()), 10'h000);
    chk("empty_end", comp_empty_out, 1'b1);
  endtask : drain

  task automatic t_reset;
    repeat (6) @(negedge clk_in);
    chk("strobe_rst", strobe_out, 2'h3);
    chk("sel_rst", sel, 3'h7);
    chk("empty_rst", comp_empty_out, 1'b1);
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("sel_run", sel, 3'h6);
  endtask : t_reset

  // more words than the chain holds, so every device hands off once
  task automatic t_stream;
    bit ok;
    for (int i = 0; i < 14; i++) push(9'h100 + 9'(i), ok);
    drain();
  endtask : t_stream

  task automatic t_fill;
    bit ok;
    int i;
    ok = 1'b1;
    i = 0;
    while (ok && i < 200) begin
      push(9'h0A5 ^ 9'(i), ok);
      i++;
    end
    chk("refused", ok, 1'b0);
    chk("saw_full", saw_full, 1'b1);
    drain();
    chk("flag_strobe", 10'(bad_strobe), 10'h000);
  endtask : t_fill

  // offered word must wait out a low enable, then still arrive
  task automatic t_freeze;
    bit ok;
    en_in = 1'b0;
    wr_data_in = 9'h15A;
    wr_valid_in = 1'b1;
    repeat (10) @(negedge clk_in);
    chk("frz_strobe", strobe_out, 2'h3);
    chk("frz_empty", comp_empty_out, 1'b1);
    en_in = 1'b1;
    push(9'h15A, ok);
    chk("frz_taken", ok, 1'b1);
    drain();
  endtask : t_freeze

  initial begin
    t_reset();
    t_stream();
    t_fill();
    t_freeze();
    end_sim();
  end
endmodule : tb_afx_host
